// File: rtl/ebp_bridge_pwm.sv
// Purpose: Enhanced PWM output stage with single, half-bridge and full-bridge modes
// Assumes: CLK is the system clock; AXI4-Lite master keeps one write and one read in flight
// Notes: Steering sync, auto-shutdown, restart and direction-change sequencing not built
//
// Behaviour
// - PWM rate follows system clock directly
// - Reset makes pins inputs, registers default
// - Config field selects single, half, full
// - Four outputs, 10-bit duty, timer period
// - Mode bits select polarity of outputs
// - No output until next period begins
// - Time base is timer plus two bits
// - Half-bridge: A is PWM, B complement
// - Dead-band delays each half-bridge inactive-to-active edge
// - Delay beyond duty keeps output inactive
// - Forward: A active, D modulated
// - Reverse: C active, B modulated
// - Single mode: steering picks driven pins
// - Pin driven only when direction is output
// - Zero control register releases the pins
// - Unused pins stay free, never driven
// - Period match clears timer, sets, latches
// - Time base equal duty clears output
// - Duty from upper register plus two bits
// - Sleep freezes timer, state and outputs
`default_nettype none

module ebp_bridge_pwm
    import ebp_pkg::*;
#(
    parameter int DB_W = 7
) (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic [ADDR_W-1:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [ADDR_W-1:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    output logic [3:0] BRIDGE_OUT,
    output logic [3:0] BRIDGE_OE
);
    localparam int CNT_W = DB_W + 2;

    generate
        if (DB_W < 1 || DB_W > 7) begin : g_bad_db
            $error("DB_W must be 1..7");
        end
    endgenerate

    // Software registers
    logic [7:0] ccp_control;
    logic [7:0] duty_upper_reg;
    logic [7:0] timer_period;
    logic [7:0] timer_control;
    logic [7:0] timer_count;
    logic [DB_W-1:0] deadband_count;
    logic [3:0] steer;
    logic [3:0] pin_direction_bits;
    logic [7:0] pwm_timer_select_low;
    logic [TSEL_HI_W-1:0] pwm_timer_select_high;
    logic sleep;

    // Bus slave state
    logic aw_held, w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [7:0] w_byte;
    logic w_lane0;
    logic aw_hs, w_hs, ar_hs, do_write;
    logic next_aw_held, next_w_held, next_rvalid, next_bvalid;
    logic wr_ctrl, wr_tcount;

    assign aw_hs = AWVALID & AWREADY;
    assign w_hs = WVALID & WREADY;
    assign ar_hs = ARVALID & ARREADY;
    assign do_write = aw_held & w_held & ~BVALID;
    assign next_aw_held = (aw_held | aw_hs) & ~do_write;
    assign next_w_held = (w_held | w_hs) & ~do_write;
    assign next_bvalid = do_write | (BVALID & ~BREADY);
    assign next_rvalid = ar_hs | (RVALID & ~RREADY);
    assign wr_ctrl = do_write & w_lane0 & (aw_addr == OFF_CTRL);
    assign wr_tcount = do_write & w_lane0 & (aw_addr == OFF_TCOUNT);

    always_ff @(posedge CLK) begin
        if (RESET) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_byte <= 8'h00;
            w_lane0 <= 1'b0;
            AWREADY <= 1'b0;
            WREADY <= 1'b0;
            BVALID <= 1'b0;
            BRESP <= RESP_OKAY;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            AWREADY <= ~next_aw_held;
            WREADY <= ~next_w_held;
            BVALID <= next_bvalid;
            if (aw_hs) begin
                aw_addr <= {AWADDR[ADDR_W-1:2], 2'h0};
            end
            if (w_hs) begin
                w_byte <= WDATA[7:0];
                w_lane0 <= WSTRB[0];
            end
            if (do_write) begin
                BRESP <= (aw_addr > OFF_STATUS) ? RESP_SLVERR : RESP_OKAY;
            end
        end
    end

    // Registers only take byte lane 0; other lanes are ignored
    always_ff @(posedge CLK) begin
        if (RESET) begin
            ccp_control <= CTRL_RST;
            duty_upper_reg <= DUTY_RST;
            timer_period <= PERIOD_RST;
            timer_control <= TCON_RST;
            deadband_count <= '0;
            steer <= STEER_RST;
            pin_direction_bits <= DIR_RST;
            pwm_timer_select_low <= TSEL_RST;
            pwm_timer_select_high <= '0;
            sleep <= 1'b0;
        end else if (do_write && w_lane0) begin
            unique case (aw_addr)
                OFF_CTRL: ccp_control <= w_byte;
                OFF_DUTY: duty_upper_reg <= w_byte;
                OFF_PERIOD: timer_period <= w_byte;
                OFF_TCON: timer_control <= w_byte;
                OFF_DEADBAND: deadband_count <= w_byte[DB_W-1:0];
                OFF_STEER: steer <= w_byte[3:0];
                OFF_DIR: pin_direction_bits <= w_byte[3:0];
                OFF_TSEL_LO: pwm_timer_select_low <= w_byte;
                OFF_TSEL_HI: pwm_timer_select_high <= w_byte[TSEL_HI_W-1:0];
                OFF_SLEEP: sleep <= w_byte[0];
                default: ;
            endcase
        end
    end

    // Time base
    logic [5:0] pre;
    logic [1:0] low2;
    logic tick, timer_on, period_start;
    logic [9:0] time_base, duty_buf, duty_shadow;
    logic [1:0] ps;

    assign ps = timer_control[TCON_PS_LSB +: 2];
    assign timer_on = timer_control[TCON_ON_BIT];
    assign duty_buf = {duty_upper_reg, ccp_control[DUTY_LO_LSB +: 2]};

    always_comb begin
        unique case (ps)
            PS_1: begin
                tick = (pre[1:0] == 2'h3);
                low2 = pre[1:0];
            end
            PS_4: begin
                tick = (pre[3:0] == 4'hf);
                low2 = pre[3:2];
            end
            default: begin
                tick = (pre == 6'h3f);
                low2 = pre[5:4];
            end
        endcase
    end

    assign time_base = {timer_count, low2};
    assign period_start = timer_on & ~sleep & tick & (timer_count == timer_period);

    // Counted straight off CLK, so the PWM rate scales with it
    always_ff @(posedge CLK) begin
        if (RESET) begin
            pre <= 6'h00;
        end else if (timer_on && !sleep) begin
            pre <= pre + 6'h01;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            timer_count <= 8'h00;
        end else if (wr_tcount) begin
            timer_count <= w_byte;
        end else if (period_start) begin
            timer_count <= 8'h00;
        end else if (timer_on && !sleep && tick) begin
            timer_count <= timer_count + 8'h01;
        end
    end

    // Modulator
    logic pwm_en, armed, pwm, pwm_lvl;
    logic [1:0] cur_cfg;
    logic cur_inv_ac, cur_inv_bd;

    assign pwm_en = (ccp_control[MODE_LSB+2 +: 2] == MODE_PWM);

    always_ff @(posedge CLK) begin
        if (RESET) begin
            duty_shadow <= 10'h000;
            pwm <= 1'b0;
        end else if (period_start) begin
            duty_shadow <= duty_buf;
            pwm <= (duty_buf != 10'h000);
        end else if (!sleep && time_base == duty_shadow) begin
            pwm <= 1'b0;
        end
    end

    // PWM level drops in the very cycle the time base hits duty; the registered pin drops one later
    assign pwm_lvl = pwm & (time_base != duty_shadow);

    // Mode and polarity latch only at a boundary, so bridge legs never glitch
    always_ff @(posedge CLK) begin
        if (RESET) begin
            armed <= 1'b0;
            cur_cfg <= CFG_SINGLE;
            cur_inv_ac <= 1'b0;
            cur_inv_bd <= 1'b0;
        end else if (!pwm_en) begin
            armed <= 1'b0;
        end else if (period_start) begin
            armed <= 1'b1;
            cur_cfg <= ccp_control[CFG_LSB +: 2];
            cur_inv_ac <= ccp_control[MODE_LSB+1];
            cur_inv_bd <= ccp_control[MODE_LSB];
        end
    end

    // Dead-band on the rising edge of each half-bridge leg
    logic [1:0] raw, del;
    logic [CNT_W-1:0] db_target;

    assign raw = {~pwm_lvl, pwm_lvl};
    assign db_target = {deadband_count, 2'h0};

    generate
        for (genvar k = 0; k < 2; k++) begin : g_db
            logic [CNT_W-1:0] cnt;
            assign del[k] = raw[k] & (cnt >= db_target);
            always_ff @(posedge CLK) begin
                if (RESET) begin
                    cnt <= '0;
                end else if (!sleep) begin
                    if (!raw[k]) begin
                        cnt <= '0;
                    end else if (cnt < db_target) begin
                        cnt <= cnt + CNT_W'(1);
                    end
                end
            end
        end
    endgenerate

    // Pin steering
    logic [3:0] next_act, next_used, next_inv;

    assign next_inv = {cur_inv_bd, cur_inv_ac, cur_inv_bd, cur_inv_ac};

    always_comb begin
        unique case (cur_cfg)
            CFG_SINGLE: begin
                next_used = steer;
                next_act = steer & {4{pwm_lvl}};
            end
            CFG_HALF: begin
                next_used = 4'h3;
                next_act = {2'h0, del[1], del[0]};
            end
            CFG_FWD: begin
                next_used = 4'hf;
                next_act = {pwm_lvl, 2'h0, 1'b1};
            end
            default: begin
                next_used = 4'hf;
                next_act = {1'b0, 1'b1, pwm_lvl, 1'b0};
            end
        endcase
        if (!armed) begin
            next_act = 4'h0;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            BRIDGE_OUT <= 4'h0;
            BRIDGE_OE <= 4'h0;
        end else if (!sleep) begin
            BRIDGE_OUT <= next_act ^ next_inv;
            BRIDGE_OE <= next_used & ~pin_direction_bits & {4{pwm_en}};
        end
    end

    // Read channel
    logic [7:0] rd_byte;
    logic [31:0] rd_word;

    always_comb begin
        rd_byte = 8'h00;
        rd_word = 32'h0000_0000;
        unique case ({ARADDR[ADDR_W-1:2], 2'h0})
            OFF_CTRL: rd_byte = ccp_control;
            OFF_DUTY: rd_byte = duty_upper_reg;
            OFF_PERIOD: rd_byte = timer_period;
            OFF_TCON: rd_byte = timer_control;
            OFF_TCOUNT: rd_byte = timer_count;
            OFF_DEADBAND: rd_byte = 8'(deadband_count);
            OFF_STEER: rd_byte = {4'h0, steer};
            OFF_DIR: rd_byte = {4'h0, pin_direction_bits};
            OFF_SHADOW: rd_word = {22'h0, duty_shadow};
            OFF_TSEL_LO: rd_byte = pwm_timer_select_low;
            OFF_TSEL_HI: rd_byte = 8'(pwm_timer_select_high);
            OFF_SLEEP: rd_byte = {7'h00, sleep};
            OFF_STATUS: rd_byte = {1'b0, cur_cfg, armed, BRIDGE_OUT};
            default: ;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            ARREADY <= 1'b0;
            RVALID <= 1'b0;
            RDATA <= 32'h0000_0000;
            RRESP <= RESP_OKAY;
        end else begin
            ARREADY <= ~next_rvalid;
            RVALID <= next_rvalid;
            if (ar_hs) begin
                RDATA <= rd_word | {24'h000000, rd_byte};
                RRESP <= (ARADDR > OFF_STATUS + 6'h3) ? RESP_SLVERR : RESP_OKAY;
            end
        end
    end

    // Checks
    a_reset_inputs: assert property (@(posedge CLK) RESET |=> BRIDGE_OE == 4'h0)
        else $error("pins not inputs after reset");
    a_release_pins: assert property (@(posedge CLK) disable iff (RESET)
        (ccp_control == 8'h00 && !sleep) |=> BRIDGE_OE == 4'h0)
        else $error("pins held with control cleared");
    a_dir_gate: assert property (@(posedge CLK) disable iff (RESET)
        (pin_direction_bits[0] && !sleep) |=> !BRIDGE_OE[0])
        else $error("pin driven while set as input");
    a_start_wait: assert property (@(posedge CLK) disable iff (RESET)
        $rose(armed) |-> $past(period_start))
        else $error("output armed mid-period");
    a_duty_latch: assert property (@(posedge CLK) disable iff (RESET)
        period_start |=> duty_shadow == $past(duty_buf) &&
        pwm == ($past(duty_buf) != 10'h000))
        else $error("duty not latched at period end");
    a_match_clear: assert property (@(posedge CLK) disable iff (RESET)
        (!sleep && !period_start && time_base == duty_shadow) |=> !pwm)
        else $error("output not cleared on duty match");
    a_fwd_drive: assert property (@(posedge CLK) disable iff (RESET)
        (armed && pwm_en && !period_start && !sleep && cur_cfg == CFG_FWD) |=>
        BRIDGE_OUT == ({$past(pwm_lvl), 2'h0, 1'b1} ^ $past(next_inv)))
        else $error("forward bridge pins wrong");
    a_rev_drive: assert property (@(posedge CLK) disable iff (RESET)
        (armed && pwm_en && !period_start && !sleep && cur_cfg == CFG_REV) |=>
        BRIDGE_OUT == ({2'h1, $past(pwm_lvl), 1'b0} ^ $past(next_inv)))
        else $error("reverse bridge pins wrong");
    a_half_unused: assert property (@(posedge CLK) disable iff (RESET)
        (!sleep && !period_start && cur_cfg == CFG_HALF) |=> BRIDGE_OE[3:2] == 2'h0)
        else $error("unused half-bridge pins driven");
    a_db_hold: assert property (@(posedge CLK) disable iff (RESET)
        ($rose(raw[0]) && deadband_count != '0 && !sleep) |-> !del[0] ##1 !del[0])
        else $error("dead-band not applied");
    a_sleep_freeze: assert property (@(posedge CLK) disable iff (RESET)
        (sleep && !do_write) |=> $stable(timer_count) && $stable(BRIDGE_OUT))
        else $error("state moved during sleep");

endmodule // ebp_bridge_pwm

`default_nettype wire

// File: rtl/ebp_pkg.sv
// Purpose: Shared constants for the enhanced bridge PWM output stage
// Assumes: AXI4-Lite byte addresses, 32-bit data, 8-bit registers in low lane
// Notes: Register image, field positions, reset values and mode encodings
`default_nettype none

package ebp_pkg;
    localparam int ADDR_W = 6;
    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_CTRL = 6'h00;
    localparam logic [ADDR_W-1:0] OFF_DUTY = 6'h04;
    localparam logic [ADDR_W-1:0] OFF_PERIOD = 6'h08;
    localparam logic [ADDR_W-1:0] OFF_TCON = 6'h0c;
    localparam logic [ADDR_W-1:0] OFF_TCOUNT = 6'h10;
    localparam logic [ADDR_W-1:0] OFF_DEADBAND = 6'h14;
    localparam logic [ADDR_W-1:0] OFF_STEER = 6'h18;
    localparam logic [ADDR_W-1:0] OFF_DIR = 6'h1c;
    localparam logic [ADDR_W-1:0] OFF_SHADOW = 6'h20;
    localparam logic [ADDR_W-1:0] OFF_TSEL_LO = 6'h24;
    localparam logic [ADDR_W-1:0] OFF_TSEL_HI = 6'h28;
    localparam logic [ADDR_W-1:0] OFF_SLEEP = 6'h2c;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 6'h30;
    // Control and timer control register fields, timer select width
    localparam int CFG_LSB = 6;
    localparam int DUTY_LO_LSB = 4;
    localparam int MODE_LSB = 0;
    localparam int TCON_ON_BIT = 2;
    localparam int TCON_PS_LSB = 0;
    localparam int TSEL_HI_W = 2;
    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] DUTY_RST = 8'h00;
    localparam logic [7:0] PERIOD_RST = 8'hff;
    localparam logic [7:0] TCON_RST = 8'h00;
    localparam logic [7:0] TSEL_RST = 8'h00;
    localparam logic [3:0] STEER_RST = 4'h1;
    localparam logic [3:0] DIR_RST = 4'hf;
    // Output configuration and mode field encodings
    localparam logic [1:0] CFG_SINGLE = 2'h0;
    localparam logic [1:0] CFG_FWD = 2'h1;
    localparam logic [1:0] CFG_HALF = 2'h2;
    localparam logic [1:0] CFG_REV = 2'h3;
    localparam logic [1:0] MODE_PWM = 2'h3;
    // Prescale select codes
    localparam logic [1:0] PS_1 = 2'h0;
    localparam logic [1:0] PS_4 = 2'h1;
    // System clocks per instruction cycle
    localparam int CLK_PER_TCY = 4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ebp_pkg

`default_nettype wire

// File: sim/ebp_switch_model.sv
// Purpose: Switch driver stage seen by the bridge pins
// Assumes: Driver inputs carry pull-downs
// Notes: Released pins read low; counts A/B overlap when asked
`default_nettype none

module ebp_switch_model (
    input wire logic clk,
    input wire logic [3:0] drive,
    input wire logic [3:0] oe,
    input wire logic hb_check,
    output logic [3:0] pin,
    output int shoot
);
    int overlap = 0;

    // Pull-down wins on any pin the stage leaves undriven
    assign pin = drive & oe;
    assign shoot = overlap;

    // Both half-bridge switches on would short the supply
    always @(posedge clk) begin
        if (hb_check && pin[0] && pin[1]) begin
            overlap++;
        end
    end
endmodule // ebp_switch_model

`default_nettype wire

// File: sim/tb_top.sv
// Purpose: Self-checking bench for the bridge PWM stage
// Assumes: Period 3 at 1:1 prescale gives 16 clocks per PWM period
// Notes: Counts are taken over one full period after three settle periods
`default_nettype none

module tb_top
    import ebp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'h0;
    logic reset = 1'h1;
    logic [ADDR_W-1:0] awaddr = '0;
    logic [ADDR_W-1:0] araddr = '0;
    logic awvalid = 1'h0;
    logic wvalid = 1'h0;
    logic bready = 1'h0;
    logic arvalid = 1'h0;
    logic rready = 1'h0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = '0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rsp;
    logic [31:0] rdata, rd;
    logic [3:0] bout, boe, pin, held;
    logic hb = 1'h0;
    int shoot;
    int miscompares = 0;
    int num_checks = 0;
    int k;
    localparam logic [ADDR_W-1:0] RA [10] = '{OFF_CTRL, OFF_DUTY, OFF_PERIOD, OFF_TCON,
        OFF_TCOUNT, OFF_DEADBAND, OFF_STEER, OFF_DIR, OFF_TSEL_LO, OFF_TSEL_HI};
    localparam logic [31:0] RV [10] = '{32'(CTRL_RST), 32'(DUTY_RST), 32'(PERIOD_RST),
        32'(TCON_RST), 32'h0, 32'h0, 32'(STEER_RST), 32'(DIR_RST), 32'(TSEL_RST), 32'h0};

    always #5 clk = ~clk;

    ebp_bridge_pwm ebp_bridge_pwm_i (.CLK(clk), .RESET(reset), .AWADDR(awaddr),
        .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid),
        .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr),
        .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
        .RREADY(rready), .BRIDGE_OUT(bout), .BRIDGE_OE(boe));

    ebp_switch_model ebp_switch_model_i (.clk(clk), .drive(bout), .oe(boe), .hb_check(hb),
        .pin(pin), .shoot(shoot));

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tmo();
        miscompares++;
        $display("ERROR t=%0t bus wait expired", $time);
        results();
    endtask

    // Response waits on bvalid only; it cannot rise before both halves are taken
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        wstrb <= 4'hf;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (n < 100) begin
            @(posedge clk);
            n++;
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
            if (bvalid) begin
                rsp = bresp;
                bready <= 1'h0;
                n = 200;
            end
        end
        if (n < 200) tmo();
    endtask

    task automatic rdreg(input logic [ADDR_W-1:0] a);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        while (n < 100) begin
            @(posedge clk);
            n++;
            if (arvalid && arready) arvalid <= 1'h0;
            if (rvalid) begin
                rd = rdata;
                rsp = rresp;
                rready <= 1'h0;
                n = 200;
            end
        end
        if (n < 200) tmo();
    endtask

    // High time per pin over one period, after config has crossed a boundary
    task automatic measure(input int ea, input int eb, input int ec, input int ed);
        int c[4];
        c = '{0, 0, 0, 0};
        repeat (48) @(posedge clk);
        repeat (16) begin
            @(posedge clk);
            for (int i = 0; i < 4; i++) c[i] += pin[i];
        end
        chk(c[0], ea);
        chk(c[1], eb);
        chk(c[2], ec);
        chk(c[3], ed);
    endtask

    initial begin
        repeat (4) @(posedge clk);
        reset <= 1'h0;
        chk(boe, 4'h0);
        for (int i = 0; i < 10; i++) begin
            rdreg(RA[i]);
            chk(rd, RV[i]);
        end
        wr(6'h34, 8'h55);
        chk(rsp, RESP_SLVERR);
        rdreg(6'h34);
        chk(rd, 32'h0);
        chk(rsp, RESP_SLVERR);
        $display("test reset_map done");
        wr(OFF_PERIOD, 8'h03);
        wr(OFF_DUTY, 8'h01);
        wr(OFF_CTRL, 8'h2c);
        wr(OFF_STEER, 8'h05);
        wr(OFF_DIR, 8'h00);
        wr(OFF_TCON, 8'h04);
        k = 0;
        repeat (6) begin
            @(posedge clk);
            k += pin[0];
        end
        chk(k, 0);
        measure(6, 0, 6, 0);
        chk(boe, 4'h5);
        rdreg(OFF_SHADOW);
        chk(rd, 32'h6);
        wr(OFF_DUTY, 8'h00);
        wr(OFF_CTRL, 8'h0c);
        measure(0, 0, 0, 0);
        wr(OFF_STEER, 8'h0f);
        wr(OFF_DIR, 8'h0e);
        repeat (4) @(posedge clk);
        chk(boe, 4'h1);
        wr(OFF_DIR, 8'h00);
        $display("test single done");
        wr(OFF_DUTY, 8'h02);
        wr(OFF_DEADBAND, 8'h01);
        wr(OFF_CTRL, 8'h8c);
        hb <= 1'h1;
        measure(4, 4, 0, 0);
        chk(boe[3:2], 2'h0);
        wr(OFF_DEADBAND, 8'h03);
        measure(0, 0, 0, 0);
        hb <= 1'h0;
        chk(shoot, 0);
        wr(OFF_DEADBAND, 8'h00);
        $display("test half done");
        wr(OFF_CTRL, 8'h4c);
        measure(16, 0, 0, 8);
        wr(OFF_CTRL, 8'hcc);
        measure(0, 8, 16, 0);
        wr(OFF_CTRL, 8'h4f);
        measure(0, 16, 16, 8);
        $display("test full done");
        wr(OFF_CTRL, 8'h4c);
        repeat (40) @(posedge clk);
        wr(OFF_SLEEP, 8'h01);
        rdreg(OFF_TCOUNT);
        k = rd;
        held = bout;
        repeat (20) @(posedge clk);
        chk(bout, held);
        rdreg(OFF_TCOUNT);
        chk(rd, k);
        wr(OFF_SLEEP, 8'h00);
        measure(16, 0, 0, 8);
        wr(OFF_CTRL, 8'h00);
        repeat (40) @(posedge clk);
        chk(boe, 4'h0);
        $display("test sleep_release done");
        results();
    end
endmodule // tb_top

`default_nettype wire
